// [inc/cls_defines.svh]
`ifndef CLS_DEFINES_SVH
`define CLS_DEFINES_SVH

// Number of cache lines tracked and the width of a line index.
`define CLS_NUM_LINES 64
`define CLS_INDEX_W 6

// Depth of the pin synchroniser.
`define CLS_SYNC_STAGES 3

`endif

// [inc/cls_pkg.sv]
package cls_pkg;

    // Four-state coherency of one cache line.
    typedef enum logic [1:0] {
        LINE_INVALID,
        LINE_SHARED,
        LINE_EXCLUSIVE,
        LINE_MODIFIED
    } line_state_e;

    // Controller sequence.
    typedef enum logic {
        CTL_IDLE,
        CTL_WT_BUS
    } ctl_state_e;

endpackage

// [inc/line_state_if.sv]
`timescale 1ns/1ps
// Carries the state array ports between the controller and the array.
interface line_state_if #(
    parameter int INDEX_W = 6
);
    import cls_pkg::*;
    logic [INDEX_W-1:0] rd_a_idx;
    line_state_e rd_a_state;
    logic [INDEX_W-1:0] rd_b_idx;
    line_state_e rd_b_state;
    logic we;
    logic [INDEX_W-1:0] wr_idx;
    line_state_e wr_state;

    modport ctrl (output rd_a_idx, rd_b_idx, we, wr_idx, wr_state, input rd_a_state, rd_b_state);
    modport store (input rd_a_idx, rd_b_idx, we, wr_idx, wr_state, output rd_a_state, rd_b_state);
endinterface

// [design/line_state_array.sv]
`timescale 1ns/1ps
`include "cls_defines.svh"
// State bits of every line, two read ports and one write port.
module line_state_array #(
    parameter int NUM_LINES = `CLS_NUM_LINES,
    parameter int INDEX_W = `CLS_INDEX_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    line_state_if.store ls
);
    import cls_pkg::*;

    line_state_e state_ff [NUM_LINES];

    // Each entry clears to invalid on reset and takes the write port when addressed.
    generate
        for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    state_ff[g] <= LINE_INVALID;
                end else if (ls.we && ls.wr_idx == INDEX_W'(g)) begin
                    state_ff[g] <= ls.wr_state;
                end
            end
        end
    endgenerate

    // Asynchronous read ports.
    assign ls.rd_a_state = state_ff[ls.rd_a_idx];
    assign ls.rd_b_state = state_ff[ls.rd_b_idx];
endmodule // line_state_array

// [design/cache_line_state_update.sv]
`timescale 1ns/1ps
`include "cls_defines.svh"
// Overview of operation
// - A write hit to a shared line with page_write_through low samples line_policy_select during its bus cycle.
// - The state chosen from that sample applies to the whole line, however little of it was written.
// - A high sample promotes the shared line to exclusive, except when a snoop hit claims the write port in the completing cycle.
// - A low sample leaves the line shared.
// - A snoop hit with snoop_invalidate low moves the line to shared from modified, exclusive or shared.
module cache_line_state_update #(
    parameter int NUM_LINES = `CLS_NUM_LINES,
    parameter int INDEX_W = `CLS_INDEX_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic core_wr_req_i,
    input wire logic [INDEX_W-1:0] core_wr_index_i,
    input wire logic page_write_through_i,
    input wire logic core_fill_req_i,
    input wire logic [INDEX_W-1:0] core_fill_index_i,
    input wire cls_pkg::line_state_e core_fill_state_i,
    input wire logic bus_ready_i,
    input wire logic line_policy_select_i,
    input wire logic snoop_strobe_i,
    input wire logic snoop_invalidate_i,
    input wire logic [INDEX_W-1:0] snoop_index_i,
    output logic core_done_o,
    output logic core_wr_miss_o,
    output logic wt_cycle_o,
    output logic [INDEX_W-1:0] wt_index_o,
    output logic snoop_hit_o,
    output logic snoop_hit_modified_o
);
    import cls_pkg::*;

    localparam int PIN_W = INDEX_W + 4;

    line_state_if #(.INDEX_W(INDEX_W)) ls ();

    line_state_array #(
        .NUM_LINES(NUM_LINES),
        .INDEX_W(INDEX_W)
    ) u_array (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ls(ls)
    );

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_ff;
    logic [PIN_W-1:0] sync2_ff;
    logic [PIN_W-1:0] sync3_ff;
    logic [PIN_W-1:0] pin_ff;
    logic strobe_prev_ff;
    logic ready_prev_ff;
    ctl_state_e state_ff;
    logic [INDEX_W-1:0] wt_idx_ff;
    logic wt_pwt_ff;
    logic pol_f;
    logic rdy_f;
    logic inv_f;
    logic strb_f;
    logic [INDEX_W-1:0] sidx_f;
    logic snoop_evt;
    logic snoop_is_hit;
    logic wt_complete;
    logic core_take;
    line_state_e wt_next;

    assign pin_raw = {snoop_strobe_i, snoop_invalidate_i, snoop_index_i, bus_ready_i, line_policy_select_i};

    // Three-stage synchroniser for the bus controller pins.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // A pin change counts once the second and third stages agree.
    generate
        for (genvar b = 0; b < PIN_W; b++) begin : g_pin
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    pin_ff[b] <= 1'b0;
                end else if (sync2_ff[b] == sync3_ff[b]) begin
                    pin_ff[b] <= sync3_ff[b];
                end
            end
        end
    endgenerate

    assign pol_f = pin_ff[0];
    assign rdy_f = pin_ff[1];
    assign sidx_f = pin_ff[INDEX_W+1:2];
    assign inv_f = pin_ff[INDEX_W+2];
    assign strb_f = pin_ff[INDEX_W+3];

    // Edge detectors on the filtered strobes.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            strobe_prev_ff <= 1'b0;
            ready_prev_ff <= 1'b0;
        end else begin
            strobe_prev_ff <= strb_f;
            ready_prev_ff <= rdy_f;
        end
    end

    assign snoop_evt = strb_f && !strobe_prev_ff;
    assign snoop_is_hit = snoop_evt && ls.rd_b_state != LINE_INVALID;
    assign wt_complete = state_ff == CTL_WT_BUS && rdy_f && !ready_prev_ff;
    assign core_take = state_ff == CTL_IDLE && !snoop_evt && (core_wr_req_i || core_fill_req_i);

    // Port A follows the pending write-through line while busy, the core otherwise.
    assign ls.rd_a_idx = (state_ff == CTL_WT_BUS) ? wt_idx_ff : core_wr_index_i;
    assign ls.rd_b_idx = sidx_f;

    // Policy sampled at the end of the bus cycle picks the state of the entire line.
    always_comb begin
        wt_next = LINE_SHARED;
        if (!wt_pwt_ff && pol_f) begin
            wt_next = LINE_EXCLUSIVE;
        end
    end

    // Single write port: a snoop beats every core-side update in the same cycle.
    always_comb begin
        ls.we = 1'b0;
        ls.wr_idx = core_wr_index_i;
        ls.wr_state = LINE_INVALID;
        if (snoop_is_hit) begin
            ls.we = 1'b1;
            ls.wr_idx = sidx_f;
            ls.wr_state = inv_f ? LINE_INVALID : LINE_SHARED;
        end else if (wt_complete) begin
            ls.we = ls.rd_a_state == LINE_SHARED;
            ls.wr_idx = wt_idx_ff;
            ls.wr_state = wt_next;
        end else if (core_take && core_wr_req_i) begin
            ls.we = ls.rd_a_state == LINE_EXCLUSIVE;
            ls.wr_state = LINE_MODIFIED;
        end else if (core_take) begin
            ls.we = 1'b1;
            ls.wr_idx = core_fill_index_i;
            ls.wr_state = core_fill_state_i;
        end
    end

    // Sequencer: a write hit to a shared line starts a write-through bus cycle.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= CTL_IDLE;
            wt_idx_ff <= '0;
            wt_pwt_ff <= 1'b0;
        end else begin
            case (state_ff)
                CTL_IDLE: begin
                    if (core_take && core_wr_req_i && ls.rd_a_state == LINE_SHARED) begin
                        state_ff <= CTL_WT_BUS;
                        wt_idx_ff <= core_wr_index_i;
                        wt_pwt_ff <= page_write_through_i;
                    end
                end
                CTL_WT_BUS: begin
                    if (wt_complete) begin
                        state_ff <= CTL_IDLE;
                    end
                end
                default: state_ff <= CTL_IDLE;
            endcase
        end
    end

    // Bus cycle request and its line index stand until the bus answers.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wt_cycle_o <= 1'b0;
            wt_index_o <= '0;
        end else if (state_ff == CTL_IDLE && core_take && core_wr_req_i && ls.rd_a_state == LINE_SHARED) begin
            wt_cycle_o <= 1'b1;
            wt_index_o <= core_wr_index_i;
        end else if (wt_complete) begin
            wt_cycle_o <= 1'b0;
        end
    end

    // Core handshake pulses.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            core_done_o <= 1'b0;
            core_wr_miss_o <= 1'b0;
        end else begin
            core_done_o <= wt_complete ||
                (core_take && !(core_wr_req_i && ls.rd_a_state == LINE_SHARED));
            core_wr_miss_o <= core_take && core_wr_req_i && ls.rd_a_state == LINE_INVALID;
        end
    end

    // Snoop result pulses.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            snoop_hit_o <= 1'b0;
            snoop_hit_modified_o <= 1'b0;
        end else begin
            snoop_hit_o <= snoop_is_hit;
            snoop_hit_modified_o <= snoop_is_hit && ls.rd_b_state == LINE_MODIFIED;
        end
    end

    sequence wt_start_s;
        state_ff == CTL_IDLE && core_take && core_wr_req_i && ls.rd_a_state == LINE_SHARED;
    endsequence

    sequence wt_wait_s;
        wt_cycle_o && state_ff == CTL_WT_BUS;
    endsequence

    wt_start_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wt_start_s |=> wt_wait_s ##0 wt_index_o == $past(core_wr_index_i))
        else $error("Write hit to shared line did not start a bus cycle.");

    wt_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wt_wait_s and (!wt_complete)) |=> wt_wait_s)
        else $error("Write-through request dropped before the bus answered.");

    wt_promote_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wt_complete && !snoop_is_hit && pol_f && !wt_pwt_ff && ls.rd_a_state == LINE_SHARED
        |-> ls.we && ls.wr_state == LINE_EXCLUSIVE)
        else $error("Shared line not promoted on high policy sample.");

    wt_keep_shared_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wt_complete && !snoop_is_hit && !pol_f |-> ls.wr_state == LINE_SHARED)
        else $error("Shared line changed on low policy sample.");

    // A forced write-through page never lets the policy sample promote the line.
    wt_pwt_shared_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wt_complete && !snoop_is_hit && wt_pwt_ff |-> ls.wr_state == LINE_SHARED)
        else $error("Forced write-through line left the shared state.");

    whole_line_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wt_complete && !snoop_is_hit |-> ls.wr_idx == wt_index_o ##1 core_done_o && !wt_cycle_o)
        else $error("Write-through completion updated the wrong line.");

    snoop_share_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        snoop_is_hit && !inv_f |-> ls.we && ls.wr_idx == sidx_f && ls.wr_state == LINE_SHARED)
        else $error("Snoop hit without invalidate did not make the line shared.");

    snoop_inval_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        snoop_is_hit && inv_f |-> ls.we && ls.wr_idx == sidx_f && ls.wr_state == LINE_INVALID)
        else $error("Snoop hit with invalidate did not invalidate the line.");

    snoop_pulse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        snoop_is_hit |=> snoop_hit_o ##1 !snoop_hit_o)
        else $error("Snoop hit indication is not a single pulse.");
endmodule // cache_line_state_update

// [test/bus_ctrl_model.sv]
`timescale 1ns/1ps
// Behavioural system bus controller: answers write-through cycles and issues snoops.
module bus_ctrl_model (
    input wire logic clk_sys_i,
    input wire logic wt_cycle_i,
    input wire logic policy_i,
    input wire logic [3:0] delay_i,
    output logic bus_ready_o,
    output logic line_policy_select_o,
    output logic snoop_strobe_o,
    output logic snoop_invalidate_o,
    output logic [5:0] snoop_index_o
);
    initial begin
        bus_ready_o = 1'b0;
        line_policy_select_o = 1'b0;
        snoop_strobe_o = 1'b0;
        snoop_invalidate_o = 1'b0;
        snoop_index_o = 6'h2a;
    end

    // Answers a write-through cycle after a chosen delay; policy settles a cycle ahead of ready.
    always @(posedge clk_sys_i) begin
        if (wt_cycle_i === 1'b1 && !bus_ready_o) begin
            repeat (delay_i) @(posedge clk_sys_i);
            #1 line_policy_select_o = policy_i;
            @(posedge clk_sys_i);
            #1 bus_ready_o = 1'b1;
            while (wt_cycle_i !== 1'b0) @(posedge clk_sys_i);
            #1 bus_ready_o = 1'b0;
            line_policy_select_o = ~line_policy_select_o;
            repeat (4) @(posedge clk_sys_i);
        end
    end

    // One snoop: index held from four cycles before the strobe rise to four cycles after its fall, then scrambled.
    task automatic snoop(input logic [5:0] idx, input logic snoop_invalidate);
        @(posedge clk_sys_i);
        #1 snoop_index_o = idx;
        snoop_invalidate_o = snoop_invalidate;
        repeat (4) @(posedge clk_sys_i);
        #1 snoop_strobe_o = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1 snoop_strobe_o = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1 snoop_index_o = ~idx;
        snoop_invalidate_o = ~snoop_invalidate;
    endtask
endmodule // bus_ctrl_model

// [test/tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the line state update block.
module tb;
    import cls_pkg::*;
    logic clk_sys_i, rst_i, core_wr_req_i, page_write_through_i, core_fill_req_i, pol;
    logic [5:0] core_wr_index_i, core_fill_index_i, snoop_index_i, wt_index_o;
    line_state_e core_fill_state_i;
    logic bus_ready_i, line_policy_select_i, snoop_strobe_i, snoop_invalidate_i;
    logic core_done_o, core_wr_miss_o, wt_cycle_o, snoop_hit_o, snoop_hit_modified_o;
    logic [3:0] dly;
    int failures, total_checks, hits, mods, cycles;

    cache_line_state_update uut (.clk_sys_i, .rst_i, .core_wr_req_i, .core_wr_index_i,
        .page_write_through_i, .core_fill_req_i, .core_fill_index_i, .core_fill_state_i,
        .bus_ready_i, .line_policy_select_i, .snoop_strobe_i, .snoop_invalidate_i, .snoop_index_i,
        .core_done_o, .core_wr_miss_o, .wt_cycle_o, .wt_index_o, .snoop_hit_o, .snoop_hit_modified_o);

    bus_ctrl_model bus (.clk_sys_i, .wt_cycle_i(wt_cycle_o), .policy_i(pol), .delay_i(dly),
        .bus_ready_o(bus_ready_i), .line_policy_select_o(line_policy_select_i),
        .snoop_strobe_o(snoop_strobe_i), .snoop_invalidate_o(snoop_invalidate_i),
        .snoop_index_o(snoop_index_i));

    // Clock generation at 200 MHz.
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // Counts snoop hit pulses and cuts a hang short.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (snoop_hit_o === 1'b1) begin
            hits++;
            if (snoop_hit_modified_o === 1'b1) mods++;
        end
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One core request held until done; checks whether a bus cycle was made and the miss flag against the expected values.
    task automatic op(input logic wr, input logic [5:0] idx, input logic page_write_through, input line_state_e st,
                      input logic exp_wt, input logic exp_miss);
        logic wt;
        int n;
        @(posedge clk_sys_i);
        #1 core_wr_req_i = wr;
        core_fill_req_i = !wr;
        core_wr_index_i = idx;
        core_fill_index_i = idx;
        page_write_through_i = page_write_through;
        core_fill_state_i = st;
        wt = 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1 n++;
            if (wt_cycle_o === 1'b1 && !wt) begin
                wt = 1'b1;
                chk(wt_index_o, idx);
            end
        end while (core_done_o !== 1'b1 && n < 200);
        chk(core_done_o, 1'b1);
        chk(wt, exp_wt);
        chk(core_wr_miss_o, exp_miss);
        core_wr_req_i = 1'b0;
        core_fill_req_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
    endtask

    task automatic snp(input logic [5:0] idx, input logic snoop_invalidate, input int eh, input int em);
        int h0, m0;
        h0 = hits;
        m0 = mods;
        bus.snoop(idx, snoop_invalidate);
        repeat (4) @(posedge clk_sys_i);
        chk(8'(hits - h0), 8'(eh));
        chk(8'(mods - m0), 8'(em));
    endtask

    task automatic t_promote();
        pol = 1'b1;
        op(1'b0, 6'h01, 1'b0, LINE_SHARED, 1'b0, 1'b0);
        op(1'b1, 6'h01, 1'b0, LINE_SHARED, 1'b1, 1'b0);
        op(1'b1, 6'h01, 1'b0, LINE_SHARED, 1'b0, 1'b0);
        snp(6'h01, 1'b0, 1, 1);
        op(1'b1, 6'h01, 1'b0, LINE_SHARED, 1'b1, 1'b0);
        $display("test promote done");
    endtask

    task automatic t_stay();
        pol = 1'b0;
        dly = 4'h9;
        op(1'b0, 6'h3f, 1'b0, LINE_SHARED, 1'b0, 1'b0);
        op(1'b1, 6'h3f, 1'b0, LINE_SHARED, 1'b1, 1'b0);
        op(1'b1, 6'h3f, 1'b0, LINE_SHARED, 1'b1, 1'b0);
        pol = 1'b1;
        op(1'b1, 6'h3f, 1'b1, LINE_SHARED, 1'b1, 1'b0);
        op(1'b1, 6'h3f, 1'b0, LINE_SHARED, 1'b1, 1'b0);
        dly = 4'h2;
        $display("test stay shared done");
    endtask

    task automatic t_snoop();
        pol = 1'b1;
        op(1'b0, 6'h04, 1'b0, LINE_EXCLUSIVE, 1'b0, 1'b0);
        snp(6'h05, 1'b0, 0, 0);
        snp(6'h04, 1'b0, 1, 0);
        op(1'b1, 6'h04, 1'b0, LINE_SHARED, 1'b1, 1'b0);
        snp(6'h04, 1'b0, 1, 0);
        snp(6'h04, 1'b1, 1, 0);
        op(1'b1, 6'h04, 1'b0, LINE_SHARED, 1'b0, 1'b1);
        snp(6'h04, 1'b1, 0, 0);
        $display("test snoop done");
    endtask

    task automatic end_sim();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Main sequence: reset for four cycles, then each scenario.
    initial begin
        rst_i = 1'b1;
        core_wr_req_i = 1'b0;
        core_fill_req_i = 1'b0;
        page_write_through_i = 1'b0;
        core_wr_index_i = 6'h00;
        core_fill_index_i = 6'h00;
        core_fill_state_i = LINE_INVALID;
        pol = 1'b0;
        dly = 4'h2;
        repeat (4) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        t_promote();
        t_stay();
        t_snoop();
        end_sim();
    end
endmodule // tb
